//--- src/tsrb_map.vh
`ifndef TSRB_MAP_VH
`define TSRB_MAP_VH

// Pointer addresses
`define TSRB_PTR_RATE_RD 8'h04
`define TSRB_PTR_RATE_WR 8'h0A
`define TSRB_PTR_ADJUST 8'h18
`define TSRB_PTR_BETA 8'h25
`define TSRB_PTR_SOFT_RESET 8'hFC
`define TSRB_PTR_POR 8'h00

// Power-on values
`define TSRB_RATE_POR 8'h07
`define TSRB_ADJUST_POR 8'h00
`define TSRB_BETA_POR 4'h8

// Field layout and codes
`define TSRB_BETA_AUTO_BIT 3
`define TSRB_BETA_DISABLED 4'h7
`define TSRB_BETA_DIODE 4'hF
`define TSRB_RATE_LAST_CODE 8'h06
`define TSRB_RATE_FASTEST 3'h7
`define TSRB_GCALL_ADDR 7'h00
`define TSRB_GCALL_RESET 8'h06
`define TSRB_DEV_ADDR 7'h4C

// Ideality factor, in millionths, and the equation scale
`define TSRB_N_BASE_DIODE 32'h000F6180
`define TSRB_N_BASE_GROUNDED 32'h000F4240
`define TSRB_N_SCALE 10'h12C

// Timing
`define TSRB_CLK_MHZ 100
`define TSRB_CYC_PER_MS (`TSRB_CLK_MHZ * 1000)
`define TSRB_CONV_SLOW_MS 126
`define TSRB_CONV_FAST_MS 93
`define TSRB_BASE_PERIOD_MS 16000
`define TSRB_CONV_SLOW_CYC (`TSRB_CONV_SLOW_MS * `TSRB_CYC_PER_MS)
`define TSRB_CONV_FAST_CYC (`TSRB_CONV_FAST_MS * `TSRB_CYC_PER_MS)
`define TSRB_BASE_PERIOD_CYC (`TSRB_BASE_PERIOD_MS * `TSRB_CYC_PER_MS)

`endif

//--- src/tsrb_twi_slave.v
`timescale 1ns/1ns
`include "tsrb_map.vh"

module tsrb_twi_slave (
    input wire clk_sys,
    input wire rst,
    input wire scl_in,
    input wire sda_in,
    input wire [6:0] dev_addr,
    input wire [7:0] rd_data,
    output reg sda_oe,
    output reg byte_valid,
    output reg [7:0] byte_data,
    output reg byte_first,
    output reg byte_gcall
);
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_ADDR = 3'h1;
    localparam [2:0] S_ACK = 3'h2;
    localparam [2:0] S_WR = 3'h3;
    localparam [2:0] S_RD = 3'h4;
    localparam [2:0] S_RACK = 3'h5;

    reg [1:0] scl_sync;
    reg [1:0] sda_sync;
    reg scl_prev;
    reg sda_prev;
    reg [2:0] state;
    reg [3:0] bitcnt;
    reg [7:0] shift;
    reg rw;
    reg first;
    reg gcall;

    wire scl = scl_sync[1];
    wire sda = sda_sync[1];
    wire scl_rise = scl & ~scl_prev;
    wire scl_fall = ~scl & scl_prev;
    wire start_cond = scl & scl_prev & sda_prev & ~sda;
    wire stop_cond = scl & scl_prev & ~sda_prev & sda;
    wire addr_gcall = (shift[7:1] == `TSRB_GCALL_ADDR) & ~shift[0];
    wire addr_match = (shift[7:1] == dev_addr) | addr_gcall;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_prev <= scl;
            sda_prev <= sda;
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= S_IDLE;
            bitcnt <= 4'h0;
            shift <= 8'h00;
            rw <= 1'b0;
            first <= 1'b0;
            gcall <= 1'b0;
            sda_oe <= 1'b0;
            byte_valid <= 1'b0;
            byte_data <= 8'h00;
            byte_first <= 1'b0;
            byte_gcall <= 1'b0;
        end else begin
            byte_valid <= 1'b0;
            if (start_cond) begin
                state <= S_ADDR;
                bitcnt <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_cond) begin
                state <= S_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                case (state)
                    S_ADDR, S_WR: begin
                        shift <= {shift[6:0], sda};
                        bitcnt <= bitcnt + 4'h1;
                    end
                    S_RACK: begin
                        // Master NACK ends the read
                        if (sda) begin
                            state <= S_IDLE;
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                case (state)
                    S_ADDR: begin
                        if (bitcnt == 4'h8) begin
                            if (addr_match) begin
                                sda_oe <= 1'b1; // [RL13]
                                rw <= shift[0];
                                gcall <= addr_gcall; // [RL13]
                                first <= 1'b1;
                                state <= S_ACK;
                            end else begin
                                state <= S_IDLE;
                            end
                        end
                    end
                    S_WR: begin
                        if (bitcnt == 4'h8) begin
                            byte_valid <= 1'b1;
                            byte_data <= shift;
                            byte_first <= first;
                            byte_gcall <= gcall;
                            first <= 1'b0;
                            sda_oe <= 1'b1;
                            state <= S_ACK;
                        end
                    end
                    S_ACK: begin
                        if (rw) begin
                            sda_oe <= ~rd_data[7];
                            shift <= {rd_data[6:0], 1'b1};
                            bitcnt <= 4'h1;
                            state <= S_RD;
                        end else begin
                            sda_oe <= 1'b0;
                            bitcnt <= 4'h0;
                            state <= S_WR;
                        end
                    end
                    S_RD: begin
                        if (bitcnt == 4'h8) begin
                            sda_oe <= 1'b0;
                            state <= S_RACK;
                        end else begin
                            sda_oe <= ~shift[7];
                            shift <= {shift[6:0], 1'b1};
                            bitcnt <= bitcnt + 4'h1;
                        end
                    end
                    S_RACK: begin
                        sda_oe <= ~rd_data[7];
                        shift <= {rd_data[6:0], 1'b1};
                        bitcnt <= 4'h1;
                        state <= S_RD;
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule // tsrb_twi_slave

//--- src/tsrb_core.v
// Functional notes
// RL1 - Conversion rate register reads at 04h, writes at 0Ah, powers up 07h.
// RL2 - Rate codes 0 to 6 give 1/16 to 4 conversions/s, 7 and up give 8/s.
// RL3 - With the top beta code bit set, the sensor type is detected per run.
// RL4 - Code 0111 skips detection, assumes a diode, applies no beta factor.
// RL5 - Base ideality 1.008 for diode or disabled, 1.000 grounded collector.
// RL6 - Readback gives 1rrr for auto range rrr and 1111 for a found diode.
// RL7 - Auto range on grounded collector takes 126 ms, all else 93 ms.
// RL8 - Ideality adjust is a signed byte at pointer 18h, read and write.
// RL9 - Ideality adjust powers up 00h, leaving the base factor unchanged.
// RL10 - Effective factor is base times 300 over 300 minus the adjust.
// RL11 - Any write at pointer FCh restores every register to power-on.
// RL12 - Software reset aborts the conversion and releases both alarms.
// RL13 - The general-call address is acknowledged and its byte examined.
// RL14 - Only a general-call second byte of 06h causes a software reset.
// RL15 - The rate sets only the idle gap, never the conversion length.
// RL16 - One 4-bit beta code per remote channel, sampled at conversion start.
`timescale 1ns/1ns
`include "tsrb_map.vh"

module tsrb_core #(
    parameter [31:0] CONV_SLOW_CYC = `TSRB_CONV_SLOW_CYC,
    parameter [31:0] CONV_FAST_CYC = `TSRB_CONV_FAST_CYC,
    parameter [31:0] BASE_PERIOD_CYC = `TSRB_BASE_PERIOD_CYC
) (
    input wire clk_sys,
    input wire rst,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output wire sda_oe,
    input wire [6:0] dev_addr,
    input wire collector_grounded,
    input wire [2:0] auto_range,
    input wire alert_set,
    input wire therm_set,
    output reg alert_n,
    output reg therm_n,
    output reg conv_start,
    output reg conv_busy,
    output reg conv_slow,
    output reg beta_comp_on,
    output reg [2:0] beta_range,
    output reg [20:0] n_eff_micro
);
    localparam [1:0] C_START = 2'h0;
    localparam [1:0] C_CONV = 2'h1;
    localparam [1:0] C_IDLE = 2'h2;

    // Rate code to period shift; codes past the table run fastest
    function [2:0] rate_shift;
        input [7:0] code;
        begin
            if (code > `TSRB_RATE_LAST_CODE) begin
                rate_shift = `TSRB_RATE_FASTEST;
            end else begin
                rate_shift = code[2:0];
            end
        end
    endfunction

    // Pointer match, used for both the register write decode and the read data select
    function is_ptr;
        input [7:0] ptr;
        input [7:0] target;
        begin
            is_ptr = (ptr == target);
        end
    endfunction

    reg [7:0] conversion_rate;
    reg [7:0] ideality_adjust;
    reg [3:0] beta_select_code;
    reg [3:0] beta_status;
    reg [7:0] pointer;
    reg [7:0] rd_data;
    reg soft_rst;
    reg [1:0] cstate;
    reg [31:0] elapsed;
    reg [31:0] conv_len;
    reg [1:0] grounded_sync;
    reg [2:0] range_sync0;
    reg [2:0] range_sync1;
    reg [6:0] addr_sync0;
    reg [6:0] addr_sync1;
    reg [3:0] next_status;
    reg next_slow;
    reg next_comp;
    reg [2:0] next_range;
    reg [31:0] next_base;

    wire byte_valid;
    wire [7:0] byte_data;
    wire byte_first;
    wire byte_gcall;
    wire [31:0] period;
    wire [9:0] n_den;
    wire [31:0] n_num;
    wire [31:0] n_quot;
    wire grounded = grounded_sync[1];

    tsrb_twi_slave u_twi (
        .clk_sys(clk_sys),
        .rst(rst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .dev_addr(addr_sync1),
        .rd_data(rd_data),
        .sda_oe(sda_oe),
        .byte_valid(byte_valid),
        .byte_data(byte_data),
        .byte_first(byte_first),
        .byte_gcall(byte_gcall)
    );

    // Start-to-start period halves per rate step
    assign period = BASE_PERIOD_CYC >> rate_shift(conversion_rate); // [RL2]

    // Signed adjust widened; denominator stays in 173..428
    assign n_den = `TSRB_N_SCALE - {{2{ideality_adjust[7]}},
        ideality_adjust}; // [RL8]
    assign n_num = next_base * {22'h000000, `TSRB_N_SCALE};
    assign n_quot = n_num / {22'h000000, n_den}; // [RL10]

    // Leave idle one cycle early so start-to-start equals the period
    wire idle_done = (elapsed >= period - 32'h00000001);

    // Front-end status and address strap cross into this domain
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            grounded_sync <= 2'h0;
            range_sync0 <= 3'h0;
            range_sync1 <= 3'h0;
            addr_sync0 <= 7'h00;
            addr_sync1 <= 7'h00;
        end else begin
            grounded_sync <= {grounded_sync[0], collector_grounded};
            range_sync0 <= auto_range;
            range_sync1 <= range_sync0;
            addr_sync0 <= dev_addr;
            addr_sync1 <= addr_sync0;
        end
    end

    // Sensor classification taken at the start of each conversion
    always @* begin
        next_status = beta_select_code;
        next_slow = 1'b0;
        next_comp = 1'b0;
        next_range = beta_select_code[2:0];
        next_base = `TSRB_N_BASE_GROUNDED;
        if (beta_select_code[`TSRB_BETA_AUTO_BIT]) begin
            if (grounded) begin // [RL3]
                next_status = {1'b1, range_sync1}; // [RL6]
                next_slow = 1'b1; // [RL7]
                next_comp = 1'b1;
                next_range = range_sync1;
                next_base = `TSRB_N_BASE_GROUNDED; // [RL5]
            end else begin
                next_status = `TSRB_BETA_DIODE; // [RL6]
                next_range = 3'h0;
                next_base = `TSRB_N_BASE_DIODE; // [RL5]
            end
        end else if (beta_select_code == `TSRB_BETA_DISABLED) begin
            next_range = 3'h0; // [RL4]
            next_base = `TSRB_N_BASE_DIODE; // [RL4] [RL5]
        end else begin
            next_comp = 1'b1; // [RL6]
        end
    end

    // Register file and command decode
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            conversion_rate <= `TSRB_RATE_POR;
            ideality_adjust <= `TSRB_ADJUST_POR;
            beta_select_code <= `TSRB_BETA_POR;
            beta_status <= `TSRB_BETA_POR;
            pointer <= `TSRB_PTR_POR;
            soft_rst <= 1'b0;
        end else if (soft_rst) begin
            conversion_rate <= `TSRB_RATE_POR; // [RL11] [RL1]
            ideality_adjust <= `TSRB_ADJUST_POR; // [RL11] [RL9]
            beta_select_code <= `TSRB_BETA_POR; // [RL11]
            beta_status <= `TSRB_BETA_POR;
            pointer <= `TSRB_PTR_POR;
            soft_rst <= 1'b0;
        end else begin
            if (cstate == C_START) begin
                beta_status <= next_status; // [RL6]
            end
            if (byte_valid) begin
                if (byte_gcall) begin
                    if (byte_first &&
                        byte_data == `TSRB_GCALL_RESET) begin
                        soft_rst <= 1'b1; // [RL14]
                    end
                end else if (byte_first) begin
                    pointer <= byte_data;
                end else if (is_ptr(pointer, `TSRB_PTR_SOFT_RESET)) begin
                    soft_rst <= 1'b1; // [RL11]
                end else if (is_ptr(pointer, `TSRB_PTR_RATE_WR)) begin
                    conversion_rate <= byte_data; // [RL1]
                end else if (is_ptr(pointer, `TSRB_PTR_ADJUST)) begin
                    ideality_adjust <= byte_data; // [RL8]
                end else if (is_ptr(pointer, `TSRB_PTR_BETA)) begin
                    beta_select_code <= byte_data[3:0]; // [RL16]
                    beta_status <= byte_data[3:0];
                end
            end
        end
    end

    // Read data follows the current pointer
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else if (is_ptr(pointer, `TSRB_PTR_RATE_RD)) begin
            rd_data <= conversion_rate; // [RL1]
        end else if (is_ptr(pointer, `TSRB_PTR_ADJUST)) begin
            rd_data <= ideality_adjust; // [RL8]
        end else if (is_ptr(pointer, `TSRB_PTR_BETA)) begin
            rd_data <= {4'h0, beta_status}; // [RL6]
        end else begin
            rd_data <= 8'h00;
        end
    end

    // Conversion sequencer: run, then idle out the rest of the period
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cstate <= C_START;
            elapsed <= 32'h00000000;
            conv_len <= 32'h00000000;
            conv_start <= 1'b0;
            conv_busy <= 1'b0;
            conv_slow <= 1'b0;
            beta_comp_on <= 1'b0;
            beta_range <= 3'h0;
            n_eff_micro <= 21'h000000;
        end else if (soft_rst) begin
            cstate <= C_START; // [RL12]
            elapsed <= 32'h00000000;
            conv_start <= 1'b0;
            conv_busy <= 1'b0; // [RL12]
        end else begin
            conv_start <= 1'b0;
            case (cstate)
                C_START: begin
                    conv_start <= 1'b1;
                    conv_busy <= 1'b1;
                    conv_slow <= next_slow;
                    beta_comp_on <= next_comp;
                    beta_range <= next_range;
                    n_eff_micro <= n_quot[20:0]; // [RL10] [RL9]
                    if (next_slow) begin
                        conv_len <= CONV_SLOW_CYC; // [RL7]
                    end else begin
                        conv_len <= CONV_FAST_CYC; // [RL7]
                    end
                    elapsed <= 32'h00000001;
                    cstate <= C_CONV;
                end
                C_CONV: begin
                    // Length fixed at start, the rate never touches it
                    if (elapsed >= conv_len) begin // [RL15]
                        conv_busy <= 1'b0;
                        cstate <= C_IDLE;
                    end
                    elapsed <= elapsed + 32'h00000001;
                end
                C_IDLE: begin
                    if (idle_done) begin // [RL15] [RL2]
                        cstate <= C_START;
                    end
                    elapsed <= elapsed + 32'h00000001;
                end
                default: begin
                    cstate <= C_START;
                end
            endcase
        end
    end

    // Alarm outputs: only the set path and the reset release live here
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            alert_n <= 1'b1;
            therm_n <= 1'b1;
            sda_out <= 1'b0;
        end else if (soft_rst) begin
            alert_n <= 1'b1; // [RL12]
            therm_n <= 1'b1; // [RL12]
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            if (alert_set) begin
                alert_n <= 1'b0;
            end
            if (therm_set) begin
                therm_n <= 1'b0;
            end
        end
    end
endmodule // tsrb_core

//--- tb/tsrb_core_chk.sv
`timescale 1ns/1ns
module tsrb_core_chk #(
    parameter [31:0] CONV_SLOW_CYC = 32'h7E,
    parameter [31:0] CONV_FAST_CYC = 32'h5D,
    parameter [31:0] BASE_PERIOD_CYC = 32'h640
) (
    input wire clk_sys,
    input wire rst,
    input wire alert_set,
    input wire therm_set,
    input wire alert_n,
    input wire therm_n,
    input wire conv_start,
    input wire conv_busy,
    input wire conv_slow,
    input wire beta_comp_on,
    input wire [2:0] beta_range
);
    logic [31:0] busy_cnt;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // Cycles since the current conversion began
    always @(posedge clk_sys or posedge rst) begin
        if (rst)
            busy_cnt <= 32'h0;
        else if (conv_start)
            busy_cnt <= 32'h1;
        else if (conv_busy)
            busy_cnt <= busy_cnt + 32'h1;
    end

    a_alert_set: assert property (
        alert_set |=> !alert_n [*3]) else $error("alert not held low");
    a_therm_set: assert property (
        therm_set |=> !therm_n) else $error("therm not pulled low");
    a_alert_release: assert property (
        $rose(alert_n) |-> !conv_busy ##1 conv_start)
        else $error("alert release without abort");
    a_therm_release: assert property (
        $rose(therm_n) |-> alert_n && !conv_busy)
        else $error("therm released alone");
    a_start_pulse: assert property (
        conv_start |-> conv_busy ##1 !conv_start)
        else $error("bad conversion start pulse");
    a_busy_limit: assert property (
        conv_busy && !conv_start |->
        busy_cnt < (conv_slow ? CONV_SLOW_CYC : CONV_FAST_CYC))
        else $error("conversion too long");
    a_slow_comp: assert property (
        conv_busy && conv_slow |-> beta_comp_on)
        else $error("slow conversion without compensation");
    a_off_range: assert property (
        conv_busy && !beta_comp_on |-> beta_range == 3'h0 && !conv_slow)
        else $error("range set with compensation off");
    a_class_stable: assert property (
        conv_busy && !conv_start |-> $stable(conv_slow) && $stable(beta_range))
        else $error("class changed mid conversion");
endmodule // tsrb_core_chk

bind tsrb_core tsrb_core_chk #(
    .CONV_SLOW_CYC(CONV_SLOW_CYC),
    .CONV_FAST_CYC(CONV_FAST_CYC),
    .BASE_PERIOD_CYC(BASE_PERIOD_CYC)
) tsrb_core_chk_inst (
    .clk_sys(clk_sys), .rst(rst), .alert_set(alert_set),
    .therm_set(therm_set), .alert_n(alert_n), .therm_n(therm_n),
    .conv_start(conv_start), .conv_busy(conv_busy), .conv_slow(conv_slow),
    .beta_comp_on(beta_comp_on), .beta_range(beta_range)
);

//--- tb/tsrb_host.sv
`timescale 1ns/1ns
module tsrb_host #(
    parameter logic [6:0] ADDR = 7'h4C
) (
    input wire clk_sys,
    input wire sda,
    output logic scl,
    output logic sda_oe
);
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    // Quarter of a 160 ns bus clock
    task automatic q();
        repeat (4) @(posedge clk_sys);
        #1;
    endtask
    // Start, or repeated start from a low clock
    task automatic go();
        sda_oe = 1'b0;
        q();
        scl = 1'b1;
        q();
        sda_oe = 1'b1;
        q();
        scl = 1'b0;
        q();
    endtask
    task automatic stop();
        sda_oe = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_oe = 1'b0;
        q();
    endtask
    // Eight bits MSB first, then the ninth bit given by nine
    task automatic xfer(input logic [7:0] d, input logic nine,
        output logic [7:0] r, output logic ack);
        logic [8:0] bits;
        bits = {d, nine};
        for (int i = 8; i >= 0; i--) begin
            sda_oe = !bits[i];
            q();
            scl = 1'b1;
            q();
            if (i > 0)
                r[i - 1] = sda;
            else
                ack = !sda;
            q();
            scl = 1'b0;
            q();
        end
    endtask
    task automatic wr(input logic [7:0] a, p, d, input logic three,
        output logic ok);
        logic [7:0] r;
        logic k0, k1, k2;
        go();
        xfer(a, 1'b1, r, k0);
        xfer(p, 1'b1, r, k1);
        k2 = 1'b1;
        if (three)
            xfer(d, 1'b1, r, k2);
        stop();
        ok = k0 & k1 & k2;
    endtask
    task automatic rd(input logic [7:0] p, output logic [7:0] v,
        output logic ok);
        logic k0, k1, k2;
        go();
        xfer({ADDR, 1'b0}, 1'b1, v, k0);
        xfer(p, 1'b1, v, k1);
        go();
        xfer({ADDR, 1'b1}, 1'b1, v, k2);
        ok = k0 & k1 & k2;
        xfer(8'hFF, 1'b1, v, k0);
        stop();
    endtask
endmodule // tsrb_host

//--- tb/tsrb_core_test.sv
`timescale 1ns/1ns
`include "tsrb_map.vh"
module tsrb_core_test;
    localparam logic [31:0] SLOW = 32'h1A;
    localparam logic [31:0] FAST = 32'h13;
    localparam logic [31:0] BASE = 32'hFA0;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic grounded = 1'b0;
    logic alert_set = 1'b0;
    logic therm_set = 1'b0;
    logic [2:0] auto_range = 3'h0;
    logic scl, host_oe, dut_oe, alert_n, therm_n, conv_start, conv_busy;
    logic conv_slow, beta_comp_on;
    logic [2:0] beta_range;
    logic [20:0] n_eff_micro;
    logic [31:0] seed = 32'h6AAFA5F3;
    int mismatches = 0;
    int n_compared = 0;
    wire sda = !(host_oe || dut_oe);

    always #5 clk_sys = !clk_sys;

    tsrb_core #(
        .CONV_SLOW_CYC(SLOW), .CONV_FAST_CYC(FAST), .BASE_PERIOD_CYC(BASE)
    ) tsrb_core_inst (
        .clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda),
        .sda_out(), .sda_oe(dut_oe), .dev_addr(`TSRB_DEV_ADDR),
        .collector_grounded(grounded), .auto_range(auto_range),
        .alert_set(alert_set), .therm_set(therm_set), .alert_n(alert_n),
        .therm_n(therm_n), .conv_start(conv_start), .conv_busy(conv_busy),
        .conv_slow(conv_slow), .beta_comp_on(beta_comp_on),
        .beta_range(beta_range), .n_eff_micro(n_eff_micro)
    );
    tsrb_host #(.ADDR(`TSRB_DEV_ADDR)) tsrb_host_inst (
        .clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_oe(host_oe)
    );

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string what, input logic [31:0] e, s);
        n_compared++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %0h seen %0h", what, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] p, d);
        logic ok;
        tsrb_host_inst.wr({`TSRB_DEV_ADDR, 1'b0}, p, d, 1'b1, ok);
        chk("write ack", 32'h1, ok);
    endtask
    task automatic rd(input logic [7:0] p, output logic [7:0] v);
        logic ok;
        tsrb_host_inst.rd(p, v, ok);
        chk("read ack", 32'h1, ok);
    endtask
    // Cycles up to and including the next conversion start
    task automatic gap(output int n);
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (conv_start !== 1'b1 && n < 9000);
        if (n >= 9000)
            chk("start seen", 32'h1, 32'h0);
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #900000;
        mismatches++;
        test_done();
    end

    initial begin
        logic [7:0] v, r, adj;
        logic [3:0] c;
        logic [31:0] s;
        logic a, d, g;
        int n, k, ne, sa;
        repeat (8) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        gap(n);
        @(posedge clk_sys);
        #1;
        chk("n_eff por", `TSRB_N_BASE_DIODE, n_eff_micro);
        rd(`TSRB_PTR_RATE_RD, v);
        chk("rate por", `TSRB_RATE_POR, v);
        rd(`TSRB_PTR_ADJUST, v);
        chk("adjust por", `TSRB_ADJUST_POR, v);
        rd(`TSRB_PTR_BETA, v);
        chk("beta diode", `TSRB_BETA_DIODE, v);
        for (k = 0; k < 10; k++) begin
            s = rnd();
            r = (k < 8) ? k[7:0] : (k == 8) ? 8'h0F : s[7:0];
            wr(`TSRB_PTR_RATE_WR, r);
            rd(`TSRB_PTR_RATE_RD, v);
            chk("rate", r, v);
            gap(n);
            gap(n);
            chk("period", BASE >> ((r > 8'h06) ? 7 : r), n);
        end
        wr(`TSRB_PTR_RATE_RD, 8'h02);
        rd(`TSRB_PTR_RATE_RD, v);
        chk("rate alias", r, v);
        rd(8'h30, v);
        chk("unmapped", 32'h0, v);
        tsrb_host_inst.wr({`TSRB_DEV_ADDR ^ 7'h01, 1'b0}, 8'h0A, 8'h01,
            1'b1, g);
        chk("foreign ack", 32'h0, g);
        wr(`TSRB_PTR_RATE_WR, 8'h07);
        for (k = 0; k < 12; k++) begin
            s = rnd();
            c = (k < 8) ? k[3:0] : {1'b1, s[2:0]};
            g = (k < 8) ? s[3] : k[0];
            adj = (k == 8) ? 8'h7F : (k == 9) ? 8'h80 : s[15:8];
            grounded = g;
            auto_range = s[6:4];
            wr(`TSRB_PTR_BETA, {4'h0, c});
            wr(`TSRB_PTR_ADJUST, adj);
            rd(`TSRB_PTR_ADJUST, v);
            chk("adjust", adj, v);
            gap(n);
            @(posedge clk_sys);
            #1;
            a = c[3] && g;
            d = (c == `TSRB_BETA_DISABLED) || (c[3] && !g);
            sa = $signed(adj);
            ne = d ? int'(`TSRB_N_BASE_DIODE) : int'(`TSRB_N_BASE_GROUNDED);
            ne = ne * 300 / (300 - sa);
            chk("n_eff", ne, n_eff_micro);
            chk("slow", a, conv_slow);
            chk("comp on", !d, beta_comp_on);
            chk("range", a ? auto_range : d ? 3'h0 : c[2:0], beta_range);
            n = 1;
            while (conv_busy === 1'b1 && n < 200) begin
                @(posedge clk_sys);
                #1;
                n++;
            end
            chk("busy", (a ? SLOW : FAST), n);
            rd(`TSRB_PTR_BETA, v);
            r = a ? {5'h01, auto_range} : (d && c[3]) ? 8'h0F : {4'h0, c};
            chk("beta read", r, v);
        end
        for (k = 0; k < 3; k++) begin
            wr(`TSRB_PTR_RATE_WR, 8'h03);
            wr(`TSRB_PTR_ADJUST, 8'h55);
            alert_set = 1'b1;
            therm_set = (k != 0);
            @(posedge clk_sys);
            #1;
            alert_set = 1'b0;
            therm_set = 1'b0;
            s = rnd();
            if (k == 0) begin
                wr(`TSRB_PTR_SOFT_RESET, s[7:0]);
            end else begin
                v = (k == 1) ? `TSRB_GCALL_RESET : (s[7:0] | 8'h80);
                tsrb_host_inst.wr(8'h00, v, 8'h00, 1'b0, g);
                chk("gcall ack", 32'h1, g);
            end
            rd(`TSRB_PTR_RATE_RD, v);
            chk("rate after", k == 2 ? 8'h03 : `TSRB_RATE_POR, v);
            rd(`TSRB_PTR_ADJUST, v);
            chk("adjust after", k == 2 ? 8'h55 : 8'h00, v);
            chk("alert after", k != 2, alert_n);
            chk("therm after", k != 2, therm_n);
        end
        test_done();
    end
endmodule // tsrb_core_test
